// File: verification/scp_chk_asserts.sv
`timescale 1ns/100ps
module scp_chk (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // serial side and core ready
    input wire chip_select_low,
    input wire sclk,
    input wire so,
    input wire so_oe_b,
    input wire core_ready,
    // core side
    input wire reg_wr,
    input wire [5:0] reg_addr,
    input wire strobe,
    input wire [5:0] strobe_addr,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_ready,
    input wire tx_flush
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_sel_ok;
        $fell(chip_select_low) ##1 (core_ready && !chip_select_low && !sclk)[*4];
    endsequence
    sequence s_sel_wait;
        $fell(chip_select_low) ##1 (!core_ready && !chip_select_low && !sclk)[*4];
    endsequence
    a_ready_fast: assert property (s_sel_ok |-> !so && !so_oe_b)
        else $error("so not low after select");
    a_ready_gate: assert property (s_sel_wait |-> so)
        else $error("so low before core ready");
    a_oe_release: assert property ($rose(chip_select_low) |-> ##[1:3] so_oe_b)
        else $error("so not released after deselect");
    a_idle_high: assert property (chip_select_low[*5] |-> so && so_oe_b)
        else $error("so not idle high");
    a_strobe_range: assert property (strobe |-> strobe_addr >= 6'h30 && strobe_addr <= 6'h3d ##1 !strobe)
        else $error("strobe outside command range");
    a_strobe_defer: assert property (strobe && strobe_addr inside {6'h38, 6'h39} |-> chip_select_low)
        else $error("deferred strobe while selected");
    a_wr_spacing: assert property (reg_wr |=> !reg_wr[*8])
        else $error("register writes too close");
    a_wr_no_buffer: assert property (reg_wr |-> reg_addr != 6'h3f)
        else $error("buffer address written as register");
    a_tx_hold: assert property (tx_valid && !tx_ready && !tx_flush |=> tx_valid && $stable(tx_data))
        else $error("stalled word lost");
endmodule
bind scp_serial_config_port scp_chk i_chk (.ref_clk, .rst_b, .chip_select_low, .sclk, .so, .so_oe_b,
    .core_ready, .reg_wr, .reg_addr, .strobe, .strobe_addr, .tx_valid, .tx_data, .tx_ready, .tx_flush);

// File: verification/scp_host.sv
`timescale 1ns/100ps
module scp_host (
    // clock
    input wire ref_clk,
    // serial pins
    input wire so,
    output reg chip_select_low,
    output reg sclk,
    output reg si
);
    initial
    begin
        chip_select_low = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    task automatic hw(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask
    // select, then wait for ready low
    task automatic sel;
        integer k;
        begin
            hw(1);
            chip_select_low = 1'b0;
            k = 0;
            while (so !== 1'b0 && k < 100)
            begin
                hw(1);
                k = k + 1;
            end
        end
    endtask
    // n bits, msb first, status taken before each rise
    task automatic xfer(input [7:0] b, input integer n, output [7:0] st);
        integer i;
        begin
            st = 8'h00;
            for (i = 7; i > 7 - n; i = i - 1)
            begin
                si = b[i];
                hw(4);
                st[i] = so;
                sclk = 1'b1;
                hw(4);
                sclk = 1'b0;
            end
        end
    endtask
    // released data line shows the inverse
    task automatic desel;
        hw(4);
        chip_select_low = 1'b1;
        si = ~si;
        hw(8);
    endtask
endmodule

// File: verification/scp_serial_config_port_bench.sv
`timescale 1ns/100ps
module scp_serial_config_port_bench;
    reg ref_clk = 1'b0;
    reg rst_b = 1'b0;
    reg core_ready = 1'b1;
    reg [2:0] main_state = 3'h0;
    reg [7:0] reg_rdata = 8'h00;
    reg tx_ready = 1'b0;
    reg tx_flush = 1'b0;
    wire chip_select_low, sclk, si, so, so_oe_b, reg_wr, reg_rd, strobe, tx_valid;
    wire [5:0] reg_addr, strobe_addr;
    wire [7:0] reg_wdata, tx_data;
    integer error_cnt = 0, checks_done = 0, i, acc;
    reg [7:0] st, d, a;
    reg [7:0] q_tx[$];
    reg [13:0] q_wr[$];
    reg [5:0] q_stb[$];
    reg [5:0] q_rd[$];
    always #50 ref_clk = ~ref_clk;
    scp_host i_host (.ref_clk(ref_clk), .so(so), .chip_select_low(chip_select_low), .sclk(sclk), .si(si));
    scp_serial_config_port i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .chip_select_low(chip_select_low),
        .sclk(sclk), .si(si), .so(so), .so_oe_b(so_oe_b), .core_ready(core_ready), .main_state(main_state),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .strobe(strobe), .strobe_addr(strobe_addr), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .tx_flush(tx_flush));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task summarize;
        begin
            if (error_cnt == 0 && checks_done > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // result watcher
    always @(posedge ref_clk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            chk(tx_data, q_tx.size() ? q_tx.pop_front() : 8'hxx);
        if (strobe === 1'b1)
            chk(strobe_addr, q_stb.size() ? q_stb.pop_front() : 6'hxx);
        if (reg_wr === 1'b1)
            chk({reg_addr, reg_wdata}, q_wr.size() ? q_wr.pop_front() : 14'hxxxx);
        if (reg_rd === 1'b1)
            chk(reg_addr, q_rd.size() ? q_rd.pop_front() : 6'hxx);
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        error_cnt = error_cnt + 1;
        summarize;
    end
    initial
    begin
        void'($urandom(32'h1a72));
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        core_ready = 1'b0;
        main_state = 3'($urandom);
        fork
            i_host.sel;
            begin
                repeat (20) @(negedge ref_clk);
                chk(so, 1'b1);
                core_ready = 1'b1;
            end
        join
        d = 8'($urandom);
        q_tx.push_back(d);
        i_host.xfer(8'h3f, 8, st);
        chk(st, {1'b0, main_state, 4'hf});
        i_host.xfer(d, 8, st);
        i_host.xfer(8'h7f, 8, st);
        acc = 0;
        for (i = 0; i < 70; i = i + 1)
        begin
            d = 8'($urandom);
            i_host.xfer(d, 8, st);
            // 64 in the buffer plus 2 in the skid, first single byte already held
            chk(st[3:0], (i > 50) ? ((i < 65) ? 65 - i : 0) : 15);
            if (i < 65)
                q_tx.push_back(d);
            if (st[3:0] != 4'h0)
                acc = acc + 1;
        end
        chk(st[3:0], 4'h0);
        chk(acc, 65);
        i_host.desel;
        for (i = 0; q_tx.size() > 0 && i < 3000; i = i + 1)
        begin
            @(negedge ref_clk);
            tx_ready = 1'($urandom);
        end
        tx_ready = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk(tx_valid, 1'b0);
        for (i = 'h30; i <= 'h3d; i = i + 1)
        begin
            q_stb.push_back(6'(i));
            i_host.sel;
            i_host.xfer(8'(i), 8, st);
            i_host.desel;
        end
        a = 8'($urandom % 40);
        i_host.sel;
        i_host.xfer(8'h40 | a, 8, st);
        for (i = 0; i < 3; i = i + 1)
        begin
            d = 8'($urandom);
            q_wr.push_back({a[5:0] + 6'(i), d});
            i_host.xfer(d, 8, st);
        end
        i_host.xfer(8'h55, 5, st);
        i_host.desel;
        reg_rdata = 8'($urandom);
        q_rd.push_back(a[5:0]);
        i_host.sel;
        i_host.xfer(8'h80 | a, 8, st);
        i_host.xfer(8'h00, 8, d);
        chk(d, reg_rdata);
        i_host.desel;
        for (i = 0; i < 3; i = i + 1)
            q_rd.push_back(a[5:0] + 6'(i));
        i_host.sel;
        i_host.xfer(8'hc0 | a, 8, st);
        for (i = 0; i < 2; i = i + 1)
        begin
            i_host.xfer(8'h00, 8, d);
            chk(d, reg_rdata);
        end
        i_host.desel;
        tx_flush = 1'b1;
        @(negedge ref_clk);
        tx_flush = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(q_tx.size() + q_stb.size() + q_wr.size() + q_rd.size(), 0);
        summarize;
    end
endmodule

// File: verilog/scp_regs.vh
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
// ******************************
// header fields
// ******************************
`define SCP_HDR_RW 7
`define SCP_HDR_BURST 6
`define SCP_ADDR_W 6
// ******************************
// address map
// ******************************
`define SCP_CMD_LO 6'h30
`define SCP_CMD_HI 6'h3d
`define SCP_FIFO_ADDR 6'h3f
`define SCP_PWD_ADDR 6'h39
`define SCP_OSCILLATOR_OFF_STATE_ADDR 6'h38
// ******************************
// buffer
// ******************************
`define SCP_FIFO_DEPTH 64
`define SCP_FIFO_FULL 7'h40
`define SCP_FIFO_AW 6
`define SCP_CNT_W 7
`define SCP_FREE_SAT 7'h0f
`define SCP_BIT_LAST 3'h7
`define SCP_SKID_DEPTH 2'h2
`endif

// File: verilog/scp_serial_config_port.v
`timescale 1ns/100ps
`include "scp_regs.vh"
module scp_serial_config_port (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // serial pins
    input wire chip_select_low,
    input wire sclk,
    input wire si,
    output reg so,
    output wire so_oe_b,
    // core status
    input wire core_ready,
    input wire [2:0] main_state,
    // register access
    output reg reg_wr,
    output reg reg_rd,
    output reg [5:0] reg_addr,
    output reg [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // strobes
    output reg strobe,
    output reg [5:0] strobe_addr,
    // transmit buffer drain
    output wire tx_valid,
    output reg [7:0] tx_data,
    input wire tx_ready,
    input wire tx_flush
);

// ******************************
// synchronisers
// ******************************
reg [1:0] cs_s;
reg [1:0] ck_s;
reg [1:0] si_s;
reg ck_d;
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        cs_s <= 2'h3;
        ck_s <= 2'h0;
        si_s <= 2'h0;
        ck_d <= 1'b0;
    end
    else
    begin
        cs_s <= {cs_s[0], chip_select_low};
        ck_s <= {ck_s[0], sclk};
        si_s <= {si_s[0], si};
        ck_d <= ck_s[1];
    end
end
wire cs_act = ~cs_s[1];
wire rise = cs_act & ck_s[1] & ~ck_d;
wire fall = cs_act & ~ck_s[1] & ck_d;

// ******************************
// transmit buffer storage
// ******************************
reg [7:0] mem [0:`SCP_FIFO_DEPTH-1];
reg [`SCP_FIFO_AW-1:0] wp;
reg [`SCP_FIFO_AW-1:0] rp;
reg [`SCP_CNT_W-1:0] cnt;
wire [`SCP_CNT_W-1:0] free = `SCP_FIFO_FULL - cnt;
wire [3:0] free_sat = (free > `SCP_FREE_SAT) ? 4'hf : free[3:0];

// ******************************
// serial shifter
// ******************************
localparam ST_HDR = 2'h0;
localparam ST_DATA = 2'h1;
localparam ST_IDLE = 2'h2;
reg [1:0] st;
reg [2:0] bitn;
reg [7:0] sh;
reg [7:0] tx_sh;
reg rw;
reg burst;
reg [5:0] addr;
reg pend_pwd;
reg pend_oscillator_off_state;
reg fifo_wr;
reg [7:0] fifo_wd;
wire [7:0] byte_in = {sh[6:0], si_s[1]};
wire full = (cnt == `SCP_FIFO_FULL);
wire [7:0] status = {~core_ready, main_state, free_sat};
wire is_cmd = (byte_in[5:0] >= `SCP_CMD_LO) && (byte_in[5:0] <= `SCP_CMD_HI);

assign so_oe_b = ~cs_act;
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        st <= ST_HDR;
        bitn <= 3'h0;
        sh <= 8'h00;
        tx_sh <= 8'h00;
        so <= 1'b1;
        rw <= 1'b0;
        burst <= 1'b0;
        addr <= 6'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= 6'h00;
        reg_wdata <= 8'h00;
        strobe <= 1'b0;
        strobe_addr <= 6'h00;
        pend_pwd <= 1'b0;
        pend_oscillator_off_state <= 1'b0;
        fifo_wr <= 1'b0;
        fifo_wd <= 8'h00;
    end
    else
    begin
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        strobe <= 1'b0;
        fifo_wr <= 1'b0;
        if (!cs_act)
        begin
            // deselect ends everything; one delayed strobe fires now, pwd winning over oscillator-off state
            st <= ST_HDR;
            bitn <= 3'h0;
            so <= 1'b1;
            if (pend_pwd | pend_oscillator_off_state)
            begin
                strobe <= 1'b1;
                strobe_addr <= pend_pwd ? `SCP_PWD_ADDR : `SCP_OSCILLATOR_OFF_STATE_ADDR;
            end
            pend_pwd <= 1'b0;
            pend_oscillator_off_state <= 1'b0;
        end
        else
        begin
            if (st == ST_HDR && bitn == 3'h0 && !rise)
            begin
                so <= ~core_ready;
                tx_sh <= {status[6:0], 1'b0};
            end
            if (rise)
            begin
                sh <= byte_in;
                bitn <= bitn + 3'h1;
                if (bitn == `SCP_BIT_LAST)
                begin
                    case (st)
                    ST_HDR:
                    begin
                        rw <= byte_in[`SCP_HDR_RW];
                        burst <= byte_in[`SCP_HDR_BURST];
                        addr <= byte_in[5:0];
                        st <= ST_DATA;
                        if (!byte_in[`SCP_HDR_RW] && !byte_in[`SCP_HDR_BURST] && is_cmd)
                        begin
                            st <= ST_HDR;
                            if (byte_in[5:0] == `SCP_PWD_ADDR)
                                pend_pwd <= 1'b1;
                            else if (byte_in[5:0] == `SCP_OSCILLATOR_OFF_STATE_ADDR)
                                pend_oscillator_off_state <= 1'b1;
                            else
                            begin
                                strobe <= 1'b1;
                                strobe_addr <= byte_in[5:0];
                            end
                        end
                        else if (byte_in[`SCP_HDR_RW])
                        begin
                            reg_rd <= 1'b1;
                            reg_addr <= byte_in[5:0];
                        end
                    end
                    ST_DATA:
                    begin
                        if (addr == `SCP_FIFO_ADDR)
                        begin
                            fifo_wr <= ~rw & ~full;
                            fifo_wd <= byte_in;
                        end
                        else if (!rw)
                        begin
                            reg_wr <= 1'b1;
                            reg_addr <= addr;
                            reg_wdata <= byte_in;
                        end
                        if (burst)
                        begin
                            if (addr != `SCP_FIFO_ADDR)
                            begin
                                addr <= addr + 6'h01;
                                if (rw)
                                begin
                                    reg_rd <= 1'b1;
                                    reg_addr <= addr + 6'h01;
                                end
                            end
                        end
                        else
                            st <= ST_HDR;
                    end
                    default:
                        st <= ST_HDR;
                    endcase
                end
            end
            if (fall)
            begin
                if (bitn == 3'h0)
                begin
                    if (st == ST_DATA && rw)
                    begin
                        so <= reg_rdata[7];
                        tx_sh <= {reg_rdata[6:0], 1'b0};
                    end
                    else
                    begin
                        so <= status[7];
                        tx_sh <= {status[6:0], 1'b0};
                    end
                end
                else
                begin
                    so <= tx_sh[7];
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
            end
        end
    end
end

// ******************************
// buffer pointers and output skid
// ******************************
reg [7:0] skid [0:1];
reg [1:0] sk_n;
wire pop = (cnt != 7'h00) && (sk_n < `SCP_SKID_DEPTH) && !tx_flush;
wire deq = tx_valid & tx_ready;
assign tx_valid = (sk_n != 2'h0);
always @(posedge ref_clk)
begin
    if (fifo_wr)
        mem[wp] <= fifo_wd;
end
always @(posedge ref_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        wp <= 6'h00;
        rp <= 6'h00;
        cnt <= 7'h00;
        sk_n <= 2'h0;
        tx_data <= 8'h00;
        skid[0] <= 8'h00;
        skid[1] <= 8'h00;
    end
    else if (tx_flush)
    begin
        wp <= 6'h00;
        rp <= 6'h00;
        cnt <= 7'h00;
        sk_n <= 2'h0;
    end
    else
    begin
        if (fifo_wr)
            wp <= wp + 1'b1;
        if (pop)
            rp <= rp + 1'b1;
        cnt <= cnt + {6'h00, fifo_wr} - {6'h00, pop};
        if (deq)
        begin
            tx_data <= skid[1];
            skid[0] <= skid[1];
        end
        if (pop)
        begin
            if (sk_n == 2'h0 || (sk_n == 2'h1 && deq))
            begin
                skid[0] <= mem[rp];
                tx_data <= mem[rp];
            end
            else
                skid[1] <= mem[rp];
        end
        sk_n <= sk_n + {1'b0, pop} - {1'b0, deq};
    end
end

endmodule
